// ### include/rax_pkg.sv
// constants and types for the execute datapath of an 8-bit risc core
// assumes one core clock and a decoder that presents one instruction a cycle
// What this block does
// - add writes op1 plus op2, carry set on 8-bit overflow
// - add with carry adds incoming carry too, carry set on overflow
// - forward subtract writes op1 minus op2, carry cleared on borrow
// - forward subtract with borrow also takes one minus carry
// - reverse subtract writes op2 minus op1, carry cleared on borrow
// - reverse subtract with borrow also takes one minus carry
// - multiply gives high byte to result, low byte to upper register
// - wide left shift spreads register into upper and wrapped low bits
// - wide right shift sends bits out at bottom into upper register top
// - unsigned compare: carry cleared if op2 above op1, V is C and not Z
// - signed compare does the same on two's complement operands
// - flag export puts carry in upper bit 7, carry xor overflow in bit 6
// - flag import loads flags from operand, then shifts operand and upper
// - clock divide loads a 4-bit divider field
// - program dump starts when operand is one, stops when zero
// - data access may run alongside instruction fetch
// - every instruction completes in one clock cycle
package rax_pkg;
	localparam int DATA_W = 8;
	localparam int DIV_W  = 4;
	localparam int SHAM_W = 3;
	localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
	localparam logic [DATA_W-1:0] UPPER_RST = 8'h00;
	localparam int FLAG_C_POS = 7;
	localparam int FLAG_V_POS = 6;
	localparam int FLAG_Z_POS = 5;

	typedef enum logic [4:0] {
		RAX_NOP,
		RAX_AND,
		RAX_OR,
		RAX_XOR,
		RAX_ADD,
		RAX_ADD_WITH_CARRY_OP,
		RAX_FORWARD_MINUS_OP,
		RAX_FORWARD_MINUS_BORROW_OP,
		RAX_REVERSE_MINUS_OP,
		RAX_REVERSE_MINUS_BORROW_OP,
		RAX_UNSIGNED_PRODUCT_OP,
		RAX_SIGNED_PRODUCT_OP,
		RAX_WIDE_LEFT_SHIFT_OP,
		RAX_WIDE_RIGHT_SHIFT_OP,
		RAX_WIDE_ARITH_RIGHT_SHIFT_OP,
		RAX_UNSIGNED_COMPARE_OP,
		RAX_SIGNED_COMPARE_OP,
		RAX_FLAG_EXPORT_OP,
		RAX_FLAG_IMPORT_OP,
		RAX_CORE_CLOCK_DIVIDE_OP,
		RAX_PROGRAM_DUMP_OP,
		RAX_HALT
	} rax_op_t;

	typedef struct packed {
		logic [DATA_W-1:0] res;
		logic [DATA_W-1:0] upper;
		logic              c;
		logic              v;
		logic              z;
		logic              wr_res;
	} rax_alu_out_t;
endpackage : rax_pkg

// ### include/rax_alu_if.sv
// carries one instruction and its combinational result between the modules
// assumes the top drives the request side and the alu core drives the answer
`timescale 1ns/1ps
interface rax_alu_if;
	rax_pkg::rax_op_t                 op;
	logic [rax_pkg::DATA_W-1:0]       op1;
	logic [rax_pkg::DATA_W-1:0]       op2;
	logic [rax_pkg::SHAM_W-1:0]       sham;
	logic                             c;
	logic                             v;
	logic [rax_pkg::DATA_W-1:0]       upper;
	rax_pkg::rax_alu_out_t            out;

	modport top (output op, op1, op2, sham, c, v, upper, input out);
	modport core (input op, op1, op2, sham, c, v, upper, output out);
endinterface : rax_alu_if

// ### design/rax_alu_core.sv
// combinational arithmetic and shift unit, one instruction per cycle
// assumes the caller registers everything it produces
`timescale 1ns/1ps
module rax_alu_core
(
	rax_alu_if.core a
);
	logic [8:0]  sum;
	logic [15:0] prod;
	logic [15:0] wide;
	rax_pkg::rax_alu_out_t o;

	always_comb
	begin
		o        = '0;
		o.upper  = a.upper;
		o.c      = a.c;
		o.v      = a.v;
		sum      = 9'h000;
		prod     = 16'h0000;
		wide     = 16'h0000;
		case (a.op)
			rax_pkg::RAX_AND:
			begin
				o.res = a.op1 & a.op2;
				o.upper = o.res;
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_OR:
			begin
				o.res = a.op1 | a.op2;
				o.upper = o.res;
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_XOR:
			begin
				o.res = a.op1 ^ a.op2;
				o.upper = o.res;
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_ADD, rax_pkg::RAX_ADD_WITH_CARRY_OP:
			begin
				sum = {1'b0, a.op1} + {1'b0, a.op2}
					+ {8'h00, a.op == rax_pkg::RAX_ADD_WITH_CARRY_OP && a.c};
				o.res = sum[7:0];
				o.c = sum[8];
				o.v = (a.op1[7] == a.op2[7]) && (sum[7] != a.op1[7]);
				o.upper = o.res;
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_FORWARD_MINUS_OP, rax_pkg::RAX_FORWARD_MINUS_BORROW_OP,
			rax_pkg::RAX_UNSIGNED_COMPARE_OP:
			begin
				// carry is the inverted borrow
				sum = {1'b0, a.op1} + {1'b0, ~a.op2}
					+ {8'h00, a.op != rax_pkg::RAX_FORWARD_MINUS_BORROW_OP || a.c};
				o.res = sum[7:0];
				o.c = sum[8];
				o.v = (a.op1[7] != a.op2[7]) && (sum[7] != a.op1[7]);
				o.upper = o.res;
				o.wr_res = a.op != rax_pkg::RAX_UNSIGNED_COMPARE_OP;
			end
			rax_pkg::RAX_REVERSE_MINUS_OP, rax_pkg::RAX_REVERSE_MINUS_BORROW_OP:
			begin
				sum = {1'b0, a.op2} + {1'b0, ~a.op1}
					+ {8'h00, a.op == rax_pkg::RAX_REVERSE_MINUS_OP || a.c};
				o.res = sum[7:0];
				o.c = sum[8];
				o.v = (a.op1[7] != a.op2[7]) && (sum[7] != a.op2[7]);
				o.upper = o.res;
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_SIGNED_COMPARE_OP:
			begin
				sum = {1'b0, a.op1} + {1'b0, ~a.op2} + 9'h001;
				o.res = sum[7:0];
				o.c = !($signed(a.op2) > $signed(a.op1));
				o.upper = o.res;
			end
			rax_pkg::RAX_UNSIGNED_PRODUCT_OP:
			begin
				prod = 16'(a.op1) * 16'(a.op2);
				o.res = prod[15:8];
				o.upper = prod[7:0];
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_SIGNED_PRODUCT_OP:
			begin
				prod = {{8{a.op1[7]}}, a.op1}
					* {{8{a.op2[7]}}, a.op2};
				o.res = prod[15:8];
				o.upper = prod[7:0];
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_WIDE_LEFT_SHIFT_OP:
			begin
				// rotate-left places wrapped bits low, upper gets shifted copy
				wide = {a.op1, a.op1} << a.sham;
				o.res = wide[15:8];
				o.upper = a.op1 << a.sham;
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_WIDE_RIGHT_SHIFT_OP:
			begin
				wide = {a.op1, 8'h00} >> a.sham;
				o.res = wide[15:8];
				o.upper = wide[7:0];
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_WIDE_ARITH_RIGHT_SHIFT_OP:
			begin
				// sign propagates; amount one is left to software to avoid
				wide = 16'($signed({a.op1, 8'h00}) >>> a.sham);
				o.res = wide[15:8];
				o.upper = wide[7:0];
				o.wr_res = 1'b1;
			end
			rax_pkg::RAX_FLAG_EXPORT_OP:
			begin
				o.upper[7] = a.c;
				o.upper[6] = a.c ^ a.v;
			end
			rax_pkg::RAX_FLAG_IMPORT_OP:
			begin
				o.c = a.op1[rax_pkg::FLAG_C_POS];
				o.v = a.op1[rax_pkg::FLAG_V_POS];
				o.res = {a.op1[6:0], 1'b0};
				o.upper = {a.upper[6:0], 1'b0};
				o.wr_res = 1'b1;
			end
			default:
			begin
				o.res = 8'h00;
			end
		endcase
		if (a.op == rax_pkg::RAX_FLAG_IMPORT_OP)
			o.z = a.op1[rax_pkg::FLAG_Z_POS];
		else
			o.z = (o.res == 8'h00);
	end

	assign a.out = o;
endmodule : rax_alu_core

// ### design/rax_execute.sv
// execute datapath: registers flags, upper byte and system controls
// assumes decoder presents operands and opcode once per cycle, valid qualified
`timescale 1ns/1ps
module rax_execute
(
	input  wire logic                       mclk_in,
	input  wire logic                       srst_in,
	input  wire logic                       valid_in,
	input  wire rax_pkg::rax_op_t           op_in,
	input  wire logic [rax_pkg::DATA_W-1:0] op1_in,
	input  wire logic [rax_pkg::DATA_W-1:0] op2_in,
	input  wire logic [rax_pkg::SHAM_W-1:0] sham_in,
	input  wire logic [rax_pkg::DIV_W-1:0]  divn_in,
	input  wire logic                       dump_in,
	output logic [rax_pkg::DATA_W-1:0]      res_out,
	output logic                            res_we_out,
	output logic [rax_pkg::DATA_W-1:0]      upper_out,
	output logic                            carry_out,
	output logic                            ovf_out,
	output logic                            zero_out,
	output logic [rax_pkg::DIV_W-1:0]       divn_out,
	output logic                            dump_out,
	output logic                            halt_out
);
	typedef struct packed {
		logic [rax_pkg::DATA_W-1:0] res;
		logic                       we;
		logic [rax_pkg::DATA_W-1:0] upper;
		logic                       c;
		logic                       v;
		logic                       z;
		logic [rax_pkg::DIV_W-1:0]  divn;
		logic                       dump;
		logic                       halt;
	} rax_state_t;

	rax_state_t s_q;
	rax_state_t s_d;
	rax_alu_if  alu ();

	////////////////////////////////////////////////////////////////////////
	// operands go to the alu straight from the decoder; one cycle each
	assign alu.op    = op_in;
	assign alu.op1   = op1_in;
	assign alu.op2   = op2_in;
	assign alu.sham  = sham_in;
	assign alu.c     = s_q.c;
	assign alu.v     = s_q.v;
	assign alu.upper = s_q.upper;

	rax_alu_core i_rax_alu_core
	(
		.a (alu.core)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d    = s_q;
		s_d.we = 1'b0;
		if (valid_in && !s_q.halt)
		begin
			s_d.res   = alu.out.res;
			s_d.we    = alu.out.wr_res;
			s_d.upper = alu.out.upper;
			case (op_in)
				rax_pkg::RAX_AND, rax_pkg::RAX_OR, rax_pkg::RAX_XOR:
					s_d.z = alu.out.z;
				rax_pkg::RAX_ADD, rax_pkg::RAX_ADD_WITH_CARRY_OP,
				rax_pkg::RAX_FORWARD_MINUS_OP,
				rax_pkg::RAX_FORWARD_MINUS_BORROW_OP,
				rax_pkg::RAX_REVERSE_MINUS_OP,
				rax_pkg::RAX_REVERSE_MINUS_BORROW_OP,
				rax_pkg::RAX_FLAG_IMPORT_OP:
				begin
					s_d.c = alu.out.c;
					s_d.v = alu.out.v;
					s_d.z = alu.out.z;
				end
				rax_pkg::RAX_UNSIGNED_COMPARE_OP,
				rax_pkg::RAX_SIGNED_COMPARE_OP:
				begin
					s_d.c = alu.out.c;
					s_d.z = alu.out.z;
					s_d.v = alu.out.c && !alu.out.z;
				end
				rax_pkg::RAX_CORE_CLOCK_DIVIDE_OP:
					s_d.divn = divn_in;
				rax_pkg::RAX_PROGRAM_DUMP_OP:
					s_d.dump = dump_in;
				rax_pkg::RAX_HALT:
					s_d.halt = 1'b1;
				default:
					s_d.halt = s_q.halt;
			endcase
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			s_q       <= '0;
			s_q.upper <= rax_pkg::UPPER_RST;
			s_q.divn  <= rax_pkg::DIV_RST;
		end
		else
			s_q <= s_d;
	end

	// result leaves on its own port, data bus stays free for the fetch side
	assign res_out    = s_q.res;
	assign res_we_out = s_q.we;
	assign upper_out  = s_q.upper;
	assign carry_out  = s_q.c;
	assign ovf_out    = s_q.v;
	assign zero_out   = s_q.z;
	assign divn_out   = s_q.divn;
	assign dump_out   = s_q.dump;
	assign halt_out   = s_q.halt;

	////////////////////////////////////////////////////////////////////////
	property p_add_carry;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_ADD |=>
		{carry_out, res_out} == 9'($past(op1_in)) + 9'($past(op2_in));
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add wrong");

	property p_adc;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_ADD_WITH_CARRY_OP |=>
		{carry_out, res_out} == 9'($past(op1_in)) + 9'($past(op2_in))
			+ 9'($past(carry_out));
	endproperty
	a_adc: assert property (p_adc) else $error("add carry wrong");

	property p_fsub;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_FORWARD_MINUS_OP |=>
		res_out == 8'($past(op1_in) - $past(op2_in))
		&& carry_out == ($past(op1_in) >= $past(op2_in));
	endproperty
	a_fsub: assert property (p_fsub) else $error("sub wrong");

	property p_rsub;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_REVERSE_MINUS_OP |=>
		res_out == 8'($past(op2_in) - $past(op1_in))
		&& carry_out == ($past(op2_in) >= $past(op1_in));
	endproperty
	a_rsub: assert property (p_rsub) else $error("rsub wrong");

	property p_uprod;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_UNSIGNED_PRODUCT_OP |=>
		{res_out, upper_out} == 16'($past(op1_in)) * 16'($past(op2_in));
	endproperty
	a_uprod: assert property (p_uprod) else $error("product wrong");

	property p_ucomp;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_UNSIGNED_COMPARE_OP |=>
		carry_out == !($past(op2_in) > $past(op1_in))
		&& ovf_out == (carry_out && !zero_out) && !res_we_out;
	endproperty
	a_ucomp: assert property (p_ucomp) else $error("compare wrong");

	property p_flagout;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_FLAG_EXPORT_OP |=>
		upper_out[7] == $past(carry_out)
		&& upper_out[6] == ($past(carry_out) ^ $past(ovf_out));
	endproperty
	a_flagout: assert property (p_flagout) else $error("export wrong");

	property p_logic_keep;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_XOR |=>
		$stable(carry_out) && $stable(ovf_out)
		&& zero_out == (res_out == 8'h00);
	endproperty
	a_logic_keep: assert property (p_logic_keep) else $error("xor flags");

	property p_div;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_CORE_CLOCK_DIVIDE_OP
		|=> divn_out == $past(divn_in);
	endproperty
	a_div: assert property (p_div) else $error("divider wrong");

	property p_dump;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_PROGRAM_DUMP_OP
		|=> dump_out == $past(dump_in);
	endproperty
	a_dump: assert property (p_dump) else $error("dump wrong");

	property p_fsbb;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out
		&& op_in == rax_pkg::RAX_FORWARD_MINUS_BORROW_OP |=>
		{carry_out, res_out} == {1'b0, $past(op1_in)}
			+ {1'b0, ~$past(op2_in)} + {8'h00, $past(carry_out)};
	endproperty
	a_fsbb: assert property (p_fsbb) else $error("sub borrow wrong");

	property p_rsbb;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out
		&& op_in == rax_pkg::RAX_REVERSE_MINUS_BORROW_OP |=>
		{carry_out, res_out} == {1'b0, $past(op2_in)}
			+ {1'b0, ~$past(op1_in)} + {8'h00, $past(carry_out)};
	endproperty
	a_rsbb: assert property (p_rsbb) else $error("rsub borrow wrong");

	property p_sprod;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_SIGNED_PRODUCT_OP |=>
		$signed({res_out, upper_out})
			== $signed($past(op1_in)) * $signed($past(op2_in));
	endproperty
	a_sprod: assert property (p_sprod) else $error("signed product");

	property p_wleft;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_WIDE_LEFT_SHIFT_OP |=>
		upper_out == 8'($past(op1_in) << $past(sham_in))
		&& res_out == 8'(($past(op1_in) << $past(sham_in))
			| ($past(op1_in) >> (4'h8 - 4'($past(sham_in)))));
	endproperty
	a_wleft: assert property (p_wleft) else $error("wide left wrong");

	property p_wright;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_WIDE_RIGHT_SHIFT_OP |=>
		res_out == 8'($past(op1_in) >> $past(sham_in))
		&& upper_out
			== 8'($past(op1_in) << (4'h8 - 4'($past(sham_in))));
	endproperty
	a_wright: assert property (p_wright) else $error("wide right");

	property p_scomp;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_SIGNED_COMPARE_OP |=>
		carry_out == ($signed($past(op1_in)) >= $signed($past(op2_in)))
		&& ovf_out == (carry_out && !zero_out) && !res_we_out;
	endproperty
	a_scomp: assert property (p_scomp) else $error("signed compare");

	property p_flagin;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_FLAG_IMPORT_OP |=>
		{carry_out, ovf_out, zero_out, 5'h00} == ($past(op1_in) & 8'he0)
		&& res_out == 8'($past(op1_in) << 1)
		&& upper_out == 8'($past(upper_out) << 1);
	endproperty
	a_flagin: assert property (p_flagin) else $error("import wrong");

	property p_zero;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in inside {rax_pkg::RAX_ADD,
			rax_pkg::RAX_FORWARD_MINUS_OP, rax_pkg::RAX_REVERSE_MINUS_OP}
		|=> zero_out == (res_out == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_done;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in inside {rax_pkg::RAX_AND,
			rax_pkg::RAX_UNSIGNED_PRODUCT_OP, rax_pkg::RAX_FLAG_IMPORT_OP}
		|=> res_we_out;
	endproperty
	a_done: assert property (p_done) else $error("no write back");

	property p_refuse;
		@(posedge mclk_in) disable iff (srst_in)
		!valid_in || halt_out |=> !res_we_out;
	endproperty
	a_refuse: assert property (p_refuse) else $error("idle write");

	property p_divkeep;
		@(posedge mclk_in) disable iff (srst_in)
		!(valid_in && op_in == rax_pkg::RAX_CORE_CLOCK_DIVIDE_OP)
		|=> $stable(divn_out);
	endproperty
	a_divkeep: assert property (p_divkeep) else $error("divider moved");

	property p_prodkeep;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_SIGNED_PRODUCT_OP |=>
		$stable(carry_out) && $stable(ovf_out) && $stable(zero_out);
	endproperty
	a_prodkeep: assert property (p_prodkeep) else $error("product flags");

	property p_flagkeep;
		@(posedge mclk_in) disable iff (srst_in)
		valid_in && !halt_out && op_in == rax_pkg::RAX_FLAG_EXPORT_OP |=>
		(upper_out & 8'h3f) == ($past(upper_out) & 8'h3f)
		&& $stable(carry_out) && $stable(ovf_out);
	endproperty
	a_flagkeep: assert property (p_flagkeep) else $error("export keep");
endmodule : rax_execute

// ### tb/rax_decoder_model.sv
// stand-in for the decoder and register file feeding the execute datapath
// assumes the bench calls issue or idle just after a rising clock edge
`timescale 1ns/1ps
module rax_decoder_model
(
	input  wire logic                  mclk_in,
	output logic                       valid_out,
	output rax_pkg::rax_op_t           op_out,
	output logic [rax_pkg::DATA_W-1:0] op1_out,
	output logic [rax_pkg::DATA_W-1:0] op2_out,
	output logic [rax_pkg::SHAM_W-1:0] sham_out,
	output logic [rax_pkg::DIV_W-1:0]  divn_out,
	output logic                       dump_out
);
	initial
	begin
		valid_out = 1'b0;
		op_out = rax_pkg::RAX_NOP;
		{op1_out, op2_out, sham_out, divn_out, dump_out} = 24'h5a3c96;
	end

	// one instruction, held until the edge that takes it
	task automatic issue(input rax_pkg::rax_op_t o, input logic [7:0] a,
		input logic [7:0] b, input logic [2:0] s, input logic [3:0] d,
		input logic p);
		valid_out = 1'b1;
		op_out = o;
		op1_out = a;
		op2_out = b;
		sham_out = s;
		divn_out = d;
		dump_out = p;
		@(posedge mclk_in);
		#1;
	endtask : issue

	// released operand lines flip so stale values are never trusted
	task automatic idle();
		valid_out = 1'b0;
		{op1_out, op2_out, sham_out, divn_out, dump_out} =
			~{op1_out, op2_out, sham_out, divn_out, dump_out};
		@(posedge mclk_in);
		#1;
	endtask : idle
endmodule : rax_decoder_model

// ### tb/rax_execute_tb.sv
// self-checking bench for the execute datapath
// assumes the decoder model drives inputs 1 ns after each rising edge
`timescale 1ns/1ps
module rax_execute_tb;
	typedef struct packed {
		logic [7:0] res;
		logic       we;
		logic [7:0] up;
		logic       chk_up;
		logic       c;
		logic       v;
		logic       z;
		logic [3:0] dv;
		logic       dp;
		logic       h;
	} rax_note_t;

	logic             mclk, srst, valid, dump, we, c, v, z, dpo, h;
	rax_pkg::rax_op_t op;
	logic [7:0]       op1, op2, res, up;
	logic [2:0]       sham;
	logic [3:0]       divn, dvo;
	rax_note_t        m;
	rax_note_t        nq[$];
	int               n_mismatch, n_tests, k;
	logic [16:0]      lf;
	logic [15:0]      pr[4] = '{16'h0001, 16'h0101, 16'h807f, 16'h0102};

	rax_decoder_model i_rax_decoder_model (.mclk_in(mclk), .valid_out(valid),
		.op_out(op), .op1_out(op1), .op2_out(op2), .sham_out(sham),
		.divn_out(divn), .dump_out(dump));
	rax_execute i_rax_execute (.mclk_in(mclk), .srst_in(srst),
		.valid_in(valid), .op_in(op), .op1_in(op1), .op2_in(op2),
		.sham_in(sham), .divn_in(divn), .dump_in(dump), .res_out(res),
		.res_we_out(we), .upper_out(up), .carry_out(c), .ovf_out(v),
		.zero_out(z), .divn_out(dvo), .dump_out(dpo), .halt_out(h));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr

	// expected state after one taken instruction
	function automatic rax_note_t step(input rax_note_t s,
		input rax_pkg::rax_op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic [2:0] sh, input logic [3:0] d, input logic p);
		rax_note_t  n;
		logic [8:0] t;
		logic [7:0] x, y;
		logic [15:0] w;
		logic       ci;
		int         kk;
		n = s;
		n.we = 1'b0;
		n.chk_up = 1'b1;
		x = a;
		y = b;
		ci = 1'b0;
		kk = 0;
		if (s.h)
			return n;
		case (o)
			rax_pkg::RAX_AND: {kk, n.res} = {32'd1, a & b};
			rax_pkg::RAX_OR: {kk, n.res} = {32'd1, a | b};
			rax_pkg::RAX_XOR: {kk, n.res} = {32'd1, a ^ b};
			rax_pkg::RAX_ADD: kk = 2;
			rax_pkg::RAX_ADD_WITH_CARRY_OP: {kk, ci} = {32'd2, s.c};
			rax_pkg::RAX_FORWARD_MINUS_OP: {kk, ci} = {32'd3, 1'b1};
			rax_pkg::RAX_FORWARD_MINUS_BORROW_OP: {kk, ci} = {32'd3, s.c};
			rax_pkg::RAX_REVERSE_MINUS_OP: {kk, ci, x, y} = {32'd3, 1'b1, b, a};
			rax_pkg::RAX_REVERSE_MINUS_BORROW_OP: {kk, ci, x, y} = {32'd3, s.c, b, a};
			rax_pkg::RAX_UNSIGNED_PRODUCT_OP: w = {8'h00, a} * {8'h00, b};
			rax_pkg::RAX_SIGNED_PRODUCT_OP: w = {{8{a[7]}}, a} * {{8{b[7]}}, b};
			rax_pkg::RAX_WIDE_RIGHT_SHIFT_OP: w = {a, 8'h00} >> sh;
			rax_pkg::RAX_WIDE_ARITH_RIGHT_SHIFT_OP: w = $signed({a, 8'h00}) >>> sh;
			rax_pkg::RAX_WIDE_LEFT_SHIFT_OP: w = {8'((a << sh) | (a >> (8 - sh))), 8'(a << sh)};
			rax_pkg::RAX_UNSIGNED_COMPARE_OP:
				{n.c, n.z, n.up} = {a >= b, a == b, 8'(a - b)};
			rax_pkg::RAX_SIGNED_COMPARE_OP:
				{n.c, n.z, n.up} = {$signed(a) >= $signed(b), a == b, 8'(a - b)};
			rax_pkg::RAX_FLAG_EXPORT_OP: n.up[7:6] = {s.c, s.c ^ s.v};
			rax_pkg::RAX_FLAG_IMPORT_OP: {n.c, n.v, n.z, n.res, n.up, n.we} = {a[7:5], a << 1, s.up << 1, 1'b1};
			rax_pkg::RAX_CORE_CLOCK_DIVIDE_OP: n.dv = d;
			rax_pkg::RAX_PROGRAM_DUMP_OP: n.dp = p;
			rax_pkg::RAX_HALT: n.h = 1'b1;
			default: ;
		endcase
		if (o >= rax_pkg::RAX_UNSIGNED_PRODUCT_OP && o <= rax_pkg::RAX_WIDE_ARITH_RIGHT_SHIFT_OP)
			{n.res, n.up, n.we} = {w, 1'b1};
		if (o == rax_pkg::RAX_UNSIGNED_COMPARE_OP || o == rax_pkg::RAX_SIGNED_COMPARE_OP)
			n.v = n.c & ~n.z;
		if (kk >= 2)
		begin
			y = (kk == 3) ? ~y : y;
			t = {1'b0, x} + {1'b0, y} + {8'h00, ci};
			{n.c, n.res} = t;
			n.v = (x[7] == y[7]) && (t[7] != x[7]);
		end
		if (kk >= 1)
			{n.z, n.we, n.up} = {n.res == 8'h00, 1'b1, n.res};
		return n;
	endfunction : step

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// op index follows the opcode enumeration order
	task automatic run(input int kn, input logic [7:0] a, input logic [7:0] b,
		input logic [2:0] sh, input logic [3:0] d, input logic p);
		rax_pkg::rax_op_t o;
		o = rax_pkg::rax_op_t'(kn);
		if (o == rax_pkg::RAX_WIDE_ARITH_RIGHT_SHIFT_OP && sh == 3'h1)
			sh = 3'h2;
		m = step(m, o, a, b, sh, d, p);
		nq.push_back(m);
		i_rax_decoder_model.issue(o, a, b, sh, d, p);
	endtask : run

	task automatic reset_check();
		srst = 1'b1;
		repeat (2) @(posedge mclk);
		#1 srst = 1'b0;
		m = '0;
		chk("res rst", 8'h00, res);
		chk("up rst", rax_pkg::UPPER_RST, up);
		chk("ctl rst", {4'h0, rax_pkg::DIV_RST}, {c, v, z, h, dvo});
		chk("dump rst", 8'h00, {7'h00, dpo});
	endtask : reset_check

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk)
	begin : mon
		logic      tk;
		rax_note_t e;
		tk = valid & ~srst;
		#2;
		if (tk && nq.size() > 0)
		begin
			e = nq.pop_front();
			chk("we", {7'h00, e.we}, {7'h00, we});
			if (e.we)
				chk("res", e.res, res);
			if (e.chk_up)
				chk("upper", e.up, up);
			chk("flags", {e.c, e.v, e.z, e.h, e.dv}, {c, v, z, h, dvo});
			chk("dump", {7'h00, e.dp}, {7'h00, dpo});
		end
		else if (!srst)
			chk("we idle", 8'h00, {7'h00, we});
	end

	initial
	begin
		#80000;
		n_mismatch++;
		$display("watchdog expired");
		complete_run();
	end

	initial
	begin
		n_mismatch = 0;
		n_tests = 0;
		lf = 17'h107b8;
		m = '0;
		srst = 1'b1;
		repeat (16) @(posedge mclk);
		#1 srst = 1'b0;
		run(4, 8'hff, 8'h01, 3'h0, 4'h0, 1'b0);
		run(1, 8'hf0, 8'h0f, 3'h0, 4'h0, 1'b0);
		run(5, 8'h7f, 8'h00, 3'h0, 4'h0, 1'b0);
		run(17, 8'h00, 8'h00, 3'h0, 4'h0, 1'b0);
		run(18, 8'he0, 8'h00, 3'h0, 4'h0, 1'b0);
		run(10, 8'hff, 8'hff, 3'h0, 4'h0, 1'b0);
		run(11, 8'hff, 8'h02, 3'h0, 4'h0, 1'b0);
		for (int s = 12; s <= 14; s++)
			run(s, 8'h81, 8'h00, 3'h3, 4'h0, 1'b0);
		run(14, 8'h81, 8'h00, 3'h1, 4'h0, 1'b0);
		run(19, 8'h00, 8'h00, 3'h0, 4'hf, 1'b0);
		run(20, 8'h00, 8'h00, 3'h0, 4'h0, 1'b1);
		run(20, 8'h00, 8'h00, 3'h0, 4'h0, 1'b0);
		$display("test directed done");
		for (int s = 6; s <= 9; s++)
			foreach (pr[j])
				run(s, pr[j][15:8], pr[j][7:0], 3'h0, 4'h0, 1'b0);
		$display("test subtract done");
		for (int s = 15; s <= 16; s++)
			foreach (pr[j])
			begin
				run(s, pr[j][15:8], pr[j][7:0], 3'h0, 4'h0, 1'b0);
				run(3, pr[j][7:0], 8'h3c, 3'h0, 4'h0, 1'b0);
			end
		$display("test compare done");
		for (int i = 0; i < 300; i++)
		begin
			lf = lfsr(lf);
			if (lf[16])
				i_rax_decoder_model.idle();
			k = int'(lf[15:8]) % 21;
			lf = lfsr(lf);
			run(k, lf[16:9], lf[7:0], lf[10:8], lf[14:11], lf[15]);
		end
		$display("test random done");
		run(21, 8'h00, 8'h00, 3'h0, 4'h0, 1'b0);
		run(4, 8'h01, 8'h01, 3'h0, 4'h0, 1'b0);
		run(20, 8'h00, 8'h00, 3'h0, 4'h0, 1'b1);
		i_rax_decoder_model.idle();
		reset_check();
		run(4, 8'h01, 8'h01, 3'h0, 4'h0, 1'b0);
		$display("test halt done");
		repeat (3) i_rax_decoder_model.idle();
		complete_run();
	end
endmodule : rax_execute_tb
